// ==== verilog/vsl_pkg.sv ====
// What this block does
// - address strobe starts row strobe and address pass
// - activity flag shows strobe release and refresh
// - enabled holdoff blocks local cycles and refresh
// - ack high in window: drive nothing
// - holdoff tristates least significant transceiver
// - external logic drives other transceiver enables
// - ack low returns bus to device
// - local master raises ack, waits 2T
// - holdoff stalls addressed accesses and refresh
// - missed refreshes burst first, up to 256
// - disabled holdoff: ack only completes cycles
// - read-ahead only for block reads
// - device avoids read-ahead at boundary
// - strobe release ends cycle, drops controls
// - fifo logic gates read and ack
// - block writes posted, acked before local
// - single writes acked after local completion
// - failed posted write still gets dtack
// - bus error ignored, strobe release terminates
// - one synchronous clock, counted timings
//
// Purpose: shared constants for the slave local-bus control pair
// Assumes: one clock, clk_sys at 125 MHz
// Notes:   no software-visible registers
package vsl_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned GRAB_WAIT_T       = 2;    // wait in clock periods
  localparam int unsigned REFRESH_MAX_MISS  = 256;
  localparam int unsigned REFRESH_INTERVAL  = 1000; // cycles between refresh requests
  localparam int unsigned REFRESH_LEN       = 4;    // cycles per refresh burst
  localparam int unsigned LOCAL_MIN_CYCLES  = 2;    // least local strobe width, less one clock period
  localparam int unsigned MISS_W            = 9;
  localparam logic [8:0]  MISS_RESET        = 9'h000;
  localparam logic [7:0]  BLK_BOUNDARY_MASK = 8'hff;
endpackage : vsl_pkg

// ==== verilog/vsl_if.sv ====
`timescale 1ns/1ns
// Purpose: local-bus link between the slave controller and a local master
// Assumes: all signals synchronous to clk_sys
// Notes:   the transceiver enable is a three-state style pin, low enable drives
interface vsl_if;
  logic local_cycle_ack;            // from local side
  logic local_activity_flag;        // device activity
  logic local_strobe;               // local cycle strobe
  logic local_write;                // direction of local cycle
  logic row_strobe;                 // dram row strobe
  logic refresh_active;             // refresh burst in progress
  logic transceiver_addr_drive_en;  // ls transceiver drive
  logic ls_xcvr_oe_n;               // low while device drives ls transceiver
  logic holdoff_active;             // holdoff state
  logic ext_xcvr_addr_drive_en;     // driven by local master for upper ones

  modport device (
    input  local_cycle_ack,
    input  ext_xcvr_addr_drive_en,
    output local_activity_flag,
    output local_strobe,
    output local_write,
    output row_strobe,
    output refresh_active,
    output transceiver_addr_drive_en,
    output ls_xcvr_oe_n,
    output holdoff_active
  );
  modport master (
    output local_cycle_ack,
    output ext_xcvr_addr_drive_en,
    input  local_activity_flag,
    input  local_strobe,
    input  local_write,
    input  row_strobe,
    input  refresh_active,
    input  transceiver_addr_drive_en,
    input  ls_xcvr_oe_n,
    input  holdoff_active
  );
endinterface : vsl_if

// ==== verilog/vsl_device.sv ====
`timescale 1ns/1ns
// Purpose: slave-side local cycle control: holdoff, refresh catch-up, read-ahead, posting
// Assumes: vme strobes already synchronised to clk_sys, active high here
// Notes:   bus error line deliberately absent; strobe release ends every local cycle
module vsl_device #(
  parameter int unsigned REFRESH_INTERVAL = vsl_pkg::REFRESH_INTERVAL
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic holdoff_enable,
  input  wire logic vme_as,
  input  wire logic vme_ds,
  input  wire logic vme_write,
  input  wire logic vme_block,
  input  wire logic vme_selected,
  input  wire logic [7:0] vme_addr_low,
  output logic      vme_dtack,
  vsl_if.device     lb
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_CATCHUP,
    ST_LOCAL,
    ST_DTACK,
    ST_AHEAD
  } vsl_state_e;

  vsl_state_e                  state_reg;
  logic [vsl_pkg::MISS_W-1:0]  miss_reg;
  logic [15:0]                 rtimer_reg;
  logic [2:0]                  rlen_reg;
  logic                        rpend_reg;
  logic [2:0]                  lcnt_reg;
  logic                        as_q_reg;
  logic                        act_reg;

  logic                        ref_busy;
  logic                        ref_tick;
  logic                        hold_take;
  logic                        lmin_ok;
  logic                        boundary;
  logic                        held;
  logic                        post;
  logic                        cycle_run;
  logic                        catch_go;
  logic                        routine_go;

  // a refresh burst is running while its length counter is nonzero
  assign ref_busy   = (rlen_reg != 3'd0);
  assign ref_tick   = (rtimer_reg == 16'(REFRESH_INTERVAL - 1));
  // holdoff is taken only in the strobe-high window with no refresh running,
  // so a local cycle that has already begun is never cut short
  assign hold_take  = holdoff_enable && lb.local_cycle_ack && !vme_as && !ref_busy;
  assign lmin_ok    = (lcnt_reg >= 3'(vsl_pkg::LOCAL_MIN_CYCLES));
  assign boundary   = ((vme_addr_low & vsl_pkg::BLK_BOUNDARY_MASK) == 8'h00);
  assign held       = (state_reg == ST_HOLD);
  // posted block writes take dtack as soon as the data is latched
  assign post       = (state_reg == ST_LOCAL) && vme_write && vme_block && vme_ds;
  assign cycle_run  = (state_reg == ST_LOCAL) || (state_reg == ST_AHEAD);
  // catch-up bursts outrank routine ones and any new vme access
  assign catch_go   = !ref_busy && (state_reg == ST_CATCHUP) &&
                      (miss_reg != vsl_pkg::MISS_RESET);
  assign routine_go = !ref_busy && rpend_reg && (state_reg == ST_IDLE) &&
                      !vme_as && !hold_take;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      as_q_reg <= 1'b0;
    end else if (clk_en) begin
      as_q_reg <= vme_as;
    end
  end

  // refresh interval timer; free running so missed intervals can be counted
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rtimer_reg <= 16'h0000;
    end else if (clk_en) begin
      rtimer_reg <= ref_tick ? 16'h0000 : rtimer_reg + 16'h0001;
    end
  end

  // length of the refresh burst in progress
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rlen_reg <= 3'd0;
    end else if (clk_en) begin
      if (ref_busy) begin
        rlen_reg <= rlen_reg - 3'd1;
      end else if (catch_go || routine_go) begin
        rlen_reg <= 3'(vsl_pkg::REFRESH_LEN);
      end
    end
  end

  // missed bursts are counted only while held off and saturate at the limit;
  // a longer holdoff loses refreshes, which the user must avoid
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      miss_reg <= vsl_pkg::MISS_RESET;
    end else if (clk_en) begin
      if (ref_tick && held) begin
        if (miss_reg != 9'(vsl_pkg::REFRESH_MAX_MISS)) begin
          miss_reg <= miss_reg + 9'h001;
        end
      end else if (catch_go) begin
        miss_reg <= miss_reg - 9'h001;
      end
    end
  end

  // routine refresh request; a new tick wins over the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rpend_reg <= 1'b0;
    end else if (clk_en) begin
      if (ref_tick && !held) begin
        rpend_reg <= 1'b1;
      end else if (routine_go) begin
        rpend_reg <= 1'b0;
      end
    end
  end

  // local strobe width counted in clock periods, no analog delays
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lcnt_reg <= 3'd0;
    end else if (clk_en) begin
      if (!cycle_run) begin
        lcnt_reg <= 3'd0;
      end else if (lcnt_reg != 3'd7) begin
        lcnt_reg <= lcnt_reg + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (hold_take) begin
            state_reg <= ST_HOLD;
          end else if (vme_as && vme_ds && vme_selected && !ref_busy) begin
            state_reg <= ST_LOCAL;
          end
        end

        ST_HOLD: begin
          if (!lb.local_cycle_ack) begin
            state_reg <= ST_CATCHUP;
          end
        end

        ST_CATCHUP: begin
          if (miss_reg == vsl_pkg::MISS_RESET && !ref_busy) begin
            state_reg <= ST_IDLE;
          end
        end

        ST_LOCAL: begin
          if (!vme_as) begin
            state_reg <= ST_IDLE;
          end else if (vme_write && vme_block && !vme_ds) begin
            state_reg <= ST_LOCAL;
          end else if (lmin_ok && !lb.local_cycle_ack) begin
            state_reg <= ST_DTACK;
          end
        end

        ST_DTACK: begin
          if (!vme_as) begin
            state_reg <= ST_IDLE;
          end else if (!vme_ds) begin
            state_reg <= (vme_block && !vme_write && !boundary) ? ST_AHEAD : ST_IDLE;
          end
        end

        // read-ahead is simply dropped if the strobe goes away first
        ST_AHEAD: begin
          if (!vme_as) begin
            state_reg <= ST_IDLE;
          end else if (vme_ds && lmin_ok && !lb.local_cycle_ack) begin
            state_reg <= ST_DTACK;
          end
        end

        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // activity shows strobe returning high and refresh
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_reg <= 1'b0;
    end else if (clk_en) begin
      act_reg <= (vme_as && !held) || ref_busy || (!vme_as && as_q_reg);
    end
  end

  assign vme_dtack                    = !held && ((state_reg == ST_DTACK) || post);
  assign lb.local_activity_flag       = act_reg;
  assign lb.row_strobe                = !held && (vme_as || ref_busy);
  assign lb.transceiver_addr_drive_en = !held && vme_as;
  assign lb.ls_xcvr_oe_n              = held || !vme_as;
  assign lb.local_strobe              = vme_as && cycle_run;
  assign lb.local_write               = lb.local_strobe && vme_write;
  assign lb.refresh_active            = ref_busy;
  assign lb.holdoff_active            = held;
endmodule : vsl_device

// ==== verilog/vsl_master.sv ====
`timescale 1ns/1ns
// Purpose: local-master end: takes the local bus via holdoff, acks fifo-backed cycles
// Assumes: fifo status and local requests synchronous to clk_sys
// Notes:   upper transceiver enables are driven here while the bus is owned in holdoff
module vsl_master (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic bus_request,
  input  wire logic fifo_empty,
  input  wire logic write_ok,
  output logic      bus_granted,
  output logic      fifo_read,
  vsl_if.master     lb
);
  typedef enum logic [1:0] {MS_IDLE, MS_WAIT, MS_OWN} vsl_mstate_e;

  vsl_mstate_e mst_reg;
  logic [1:0]  wait_reg;
  logic        ack_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mst_reg  <= MS_IDLE;
      wait_reg <= 2'd0;
    end else if (clk_en) begin
      case (mst_reg)
        MS_IDLE: begin
          wait_reg <= 2'd0;
          if (bus_request) begin
            mst_reg <= MS_WAIT;
          end
        end
        MS_WAIT: begin
          wait_reg <= wait_reg + 2'd1;
          if (!bus_request) begin
            mst_reg <= MS_IDLE;
          end else if (wait_reg == 2'(vsl_pkg::GRAB_WAIT_T - 1)) begin
            mst_reg <= (!lb.local_activity_flag) ? MS_OWN : MS_IDLE;
          end
        end
        MS_OWN: begin
          if (!bus_request) begin
            mst_reg <= MS_IDLE;
          end
        end
        default: mst_reg <= MS_IDLE;
      endcase
    end
  end

  // ack held high while a fifo read has no data or a write cannot finish
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= lb.local_strobe &&
                 ((!lb.local_write && fifo_empty) || (lb.local_write && !write_ok));
    end
  end

  wire holding = (mst_reg != MS_IDLE);
  // the registered hold is gated by the strobe so it never outlives the cycle
  // and is never mistaken for a holdoff request
  assign lb.local_cycle_ack        = holding || (ack_reg && lb.local_strobe);
  assign lb.ext_xcvr_addr_drive_en = lb.holdoff_active && (mst_reg == MS_OWN);
  assign bus_granted               = (mst_reg == MS_OWN) && lb.holdoff_active;
  assign fifo_read                 = lb.local_strobe && !lb.local_write && !fifo_empty;
endmodule : vsl_master

// ==== bench/vsl_monitor.sv ====
// Purpose: watches the local-bus link between the two ends
// Assumes: one clock, async active-low reset
// Notes:   sees only link signals, not the vme side
`timescale 1ns/1ns
module vsl_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic local_cycle_ack,
  input wire logic local_activity_flag,
  input wire logic local_strobe,
  input wire logic row_strobe,
  input wire logic refresh_active,
  input wire logic ls_xcvr_oe_n,
  input wire logic holdoff_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  hold_tristate_a: assert property (holdoff_active |-> ls_xcvr_oe_n)
    else $error("ls transceiver driven in holdoff");
  hold_quiet_a: assert property (holdoff_active |-> !local_strobe && !row_strobe)
    else $error("local strobe in holdoff");
  hold_norefresh_a: assert property (holdoff_active |-> !refresh_active)
    else $error("refresh during holdoff");
  hold_release_a: assert property (holdoff_active && !local_cycle_ack |-> ##[1:2] !holdoff_active)
    else $error("holdoff kept after ack low");
  hold_cause_a: assert property ($rose(holdoff_active) |-> $past(local_cycle_ack))
    else $error("holdoff without ack high");
  hold_idle_a: assert property ($rose(holdoff_active) |-> $past(!refresh_active))
    else $error("holdoff taken during refresh");
  refresh_flag_a: assert property ($rose(refresh_active) |-> ##[0:1] local_activity_flag)
    else $error("refresh not flagged");
  refresh_len_a: assert property ($rose(refresh_active) |-> refresh_active[*4])
    else $error("refresh burst too short");
  cover property (holdoff_active);
  cover property ($rose(refresh_active));
  cover property ($fell(local_strobe));
endmodule : vsl_monitor

// ==== bench/vme_slave_local_bus_control_tb.sv ====
// Purpose: runs both ends of the local-bus link together
// Assumes: short refresh interval so holdoff misses a few refreshes
// Notes:   clk_en tied high; clock gating left unexercised
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module vme_slave_local_bus_control_tb;
  logic       clk_sys = 0, reset_n = 0, clk_en = 1, holdoff_enable = 0;
  logic       vme_as = 0, vme_ds = 0, vme_write = 0, vme_block = 0, vme_selected = 0;
  logic [7:0] vme_addr_low = 8'h00;
  logic       bus_request = 0, fifo_empty = 0, write_ok = 1, saw;
  wire        vme_dtack, bus_granted, fifo_read;
  int         n_errors = 0, compares = 0, cycles = 0;
  vsl_if lb();
  vsl_device #(.REFRESH_INTERVAL(50)) i_vsl_device (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .holdoff_enable(holdoff_enable), .vme_as(vme_as), .vme_ds(vme_ds),
    .vme_write(vme_write), .vme_block(vme_block), .vme_selected(vme_selected),
    .vme_addr_low(vme_addr_low), .vme_dtack(vme_dtack), .lb(lb));
  vsl_master i_vsl_master (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .bus_request(bus_request), .fifo_empty(fifo_empty), .write_ok(write_ok),
    .bus_granted(bus_granted), .fifo_read(fifo_read), .lb(lb));
  vsl_monitor i_vsl_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
    .local_cycle_ack(lb.local_cycle_ack), .local_activity_flag(lb.local_activity_flag),
    .local_strobe(lb.local_strobe), .row_strobe(lb.row_strobe),
    .refresh_active(lb.refresh_active), .ls_xcvr_oe_n(lb.ls_xcvr_oe_n),
    .holdoff_active(lb.holdoff_active));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic vme_on(logic w, logic b);
    @(posedge clk_sys);
    {vme_as, vme_ds, vme_write, vme_block, vme_selected} <= {3'b110 | w, b, 1'b1};
    #1;
  endtask : vme_on
  task automatic vme_off();
    @(posedge clk_sys);
    {vme_as, vme_ds} <= 2'b00;
    step(2);
  endtask : vme_off
  task automatic wait_dtack(int n);
    for (int i = 0; i < n && vme_dtack !== 1'b1; i++) step(1);
  endtask : wait_dtack
  task automatic t_single_write();
    vme_on(1, 0);
    step(1);
    `CHK(vme_dtack, 1'b0)
    `CHK(lb.row_strobe, 1'b1)
    `CHK(lb.transceiver_addr_drive_en, 1'b1)
    `CHK(lb.local_write, 1'b1)
    wait_dtack(50);
    `CHK(vme_dtack, 1'b1)
    vme_off();
    `CHK(lb.local_strobe, 1'b0)
    $display("single write done");
  endtask : t_single_write
  task automatic t_block_write();
    vme_on(1, 1);
    step(1);
    `CHK(vme_dtack, 1'b1)
    vme_off();
    $display("block write done");
  endtask : t_block_write
  task automatic t_reads();
    for (int b = 0; b < 2; b++) begin
      vme_addr_low <= 8'h10;
      vme_on(0, b[0]);
      wait_dtack(50);
      `CHK(vme_dtack, 1'b1)
      @(posedge clk_sys);
      vme_ds <= 0;
      step(3);
      `CHK(lb.local_strobe, b[0])
      @(posedge clk_sys);
      vme_as <= 0;
      step(1);
      `CHK(lb.local_strobe, 1'b0)
      step(2);
    end
    $display("reads done");
  endtask : t_reads
  task automatic t_fifo();
    fifo_empty <= 1;
    vme_on(0, 0);
    step(6);
    `CHK(vme_dtack, 1'b0)
    `CHK(fifo_read, 1'b0)
    fifo_empty <= 0;
    step(1);
    `CHK(fifo_read, 1'b1)
    wait_dtack(10);
    `CHK(vme_dtack, 1'b1)
    vme_off();
    $display("fifo read done");
  endtask : t_fifo
  task automatic t_holdoff();
    holdoff_enable <= 1;
    bus_request <= 1;
    for (int i = 0; i < 20 && bus_granted !== 1'b1; i++) step(1);
    `CHK(lb.holdoff_active, 1'b1)
    `CHK(lb.ls_xcvr_oe_n, 1'b1)
    `CHK(lb.ext_xcvr_addr_drive_en, 1'b1)
    step(200);
    vme_on(0, 0);
    step(10);
    `CHK(vme_dtack, 1'b0)
    `CHK(lb.row_strobe, 1'b0)
    bus_request <= 0;
    saw = 0;
    for (int i = 0; i < 3000 && vme_dtack !== 1'b1; i++) begin
      step(1);
      saw |= lb.refresh_active;
    end
    `CHK(saw, 1'b1)
    `CHK(vme_dtack, 1'b1)
    vme_off();
    $display("holdoff done");
  endtask : t_holdoff
  task automatic t_no_holdoff();
    holdoff_enable <= 0;
    bus_request <= 1;
    saw = 0;
    for (int i = 0; i < 120; i++) begin
      step(1);
      saw |= lb.refresh_active;
    end
    `CHK(lb.holdoff_active, 1'b0)
    `CHK(saw, 1'b1)
    bus_request <= 0;
    step(2);
    $display("no holdoff done");
  endtask : t_no_holdoff
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    step(8);
    reset_n <= 1;
    step(2);
    t_single_write();
    t_block_write();
    t_reads();
    t_fifo();
    t_holdoff();
    t_no_holdoff();
    report_and_stop();
  end
endmodule : vme_slave_local_bus_control_tb
